// file: rtl/tcd_timer.sv
// Compare unit, waveform generator and dead time pairs with APB registers
// Contract
// - Count is compared with all four compare values every cycle.
// - A match sets flag A, B or D one timer clock later.
// - Enabled flag raises interrupt; servicing (status read) clears the flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Waveform built from match, PWM enables, waveform mode and output mode.
// - PWM modes buffer compare writes until top or bottom; normal mode writes at once.
// - Dead time only with PWM enabled and output mode 01.
// - Three independent dead time generators, high and low delays set separately.
// - Each generator times dead interval with a 4-bit down counter.
// - Dead time prescaler divides timer clock by 1, 2, 4 or 8.
// - On each waveform edge the rising output waits until counter reaches zero.
// - Zero comparator ends insertion when counter reaches zero.
// - Counter loads high or low dead time chosen by edge direction.
// - Outputs lag waveform by at least one timer clock; here only the rising output of a dead time pair lags.
// - Six-output mode: D pins off at 00, else channel A AND gate.
// - Timer clock is an enable on pclk, not a second clock.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module tcd_timer
  import tcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PLL status
  input wire logic pll_locked_flag,
  // Compare pins: a, a_n, b, b_n, d (pin4), d_n (pin5)
  output logic [NPIN-1:0] compare_pin,
  output logic [NPIN-1:0] compare_pin_oe,
  // Interrupt
  output logic irq
);

  tcd_state_s r;
  tcd_state_s n;

  logic [NCH-1:0] pwm_enable;
  logic [1:0] waveform_mode_sel;
  logic [NCH-1:0][1:0] compare_output_mode;
  logic six_pwm;
  logic pin4_output_gate;
  logic pin5_output_gate;
  logic [2:0] clock_sel;
  logic fast_clock_select;
  logic [DT_W-1:0] deadtime_low_value;
  logic [DT_W-1:0] deadtime_high_value;
  logic [1:0] deadtime_prescale_sel;

  assign pwm_enable = r.ctrl[CTRL_PWM_EN_LSB +: NCH];
  assign waveform_mode_sel = r.ctrl[CTRL_WGM_LSB +: 2];
  assign compare_output_mode = r.ctrl[CTRL_COM_LSB +: 2*NCH];
  assign six_pwm = r.ctrl[CTRL_PWM6_BIT];
  assign pin4_output_gate = r.ctrl[CTRL_GATE4_BIT];
  assign pin5_output_gate = r.ctrl[CTRL_GATE5_BIT];
  assign clock_sel = r.ctrl[CTRL_CS_LSB +: 3];
  assign fast_clock_select = r.ctrl[CTRL_FAST_BIT];
  assign deadtime_low_value = r.dt_cfg[DT_LOW_LSB +: DT_W];
  assign deadtime_high_value = r.dt_cfg[DT_HIGH_LSB +: DT_W];
  assign deadtime_prescale_sel = r.dt_cfg[DT_PS_LSB +: 2];

  // Timer clock enable: no second domain, every stage is qualified by it
  logic timer_clock_enable;
  logic slow_tick;
  logic [2:0] tpre_mask;
  logic [2:0] dt_mask;
  logic dt_tick;
  logic pwm_any;
  logic phase_mode;
  logic [CNT_W-1:0] top_val;
  logic at_top;
  logic at_bottom;

  assign tpre_mask = (clock_sel == 3'h0) ? 3'h0 : 3'((4'h1 << (clock_sel - 3'h1)) - 4'h1);
  // Prescaler is three bits, so every select from four up divides by eight
  assign slow_tick = (clock_sel != 3'h0) && ((r.tpre & tpre_mask) == 3'h0);
  // Fast select without lock stops the timer rather than run it on an unsettled clock
  assign timer_clock_enable = fast_clock_select ? pll_locked_flag : slow_tick;
  assign dt_mask = 3'((4'h1 << deadtime_prescale_sel) - 4'h1);
  assign dt_tick = timer_clock_enable && ((r.dtpre & dt_mask) == 3'h0);
  assign pwm_any = |pwm_enable;
  assign phase_mode = pwm_any && (waveform_mode_sel == WGM_PHASE);
  assign top_val = r.cmp_act[CMP_IDX_TOP];
  assign at_top = (r.cnt == top_val);
  assign at_bottom = (r.cnt == '0);

  // Per-channel match, waveform and dead time pair
  logic [NCH-1:0] match;
  logic [NCH-1:0] wave_nxt;
  logic [NCH-1:0][DT_W-1:0] dtc_nxt;
  logic [NCH-1:0] busy_nxt;
  logic [NCH-1:0] true_nxt;
  logic [NCH-1:0] comp_nxt;
  logic [NCH-1:0] true_oe;
  logic [NCH-1:0] comp_oe;
  logic [NPIN-1:0] pin_nxt;
  logic [NPIN-1:0] oe_nxt;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      localparam int CI = (c == 2) ? 3 : c;
      logic dt_on;
      logic edge_seen;

      assign match[c] = (r.cnt == r.cmp_act[CI]);
      assign dt_on = pwm_enable[c] && (compare_output_mode[c] == COM_PAIR);

      always_comb begin
        wave_nxt[c] = r.wave[c];
        if (timer_clock_enable) begin
          if (pwm_enable[c]) begin
            if (phase_mode) begin
              if (match[c]) begin
                wave_nxt[c] = (r.dir == TCD_DOWN);
              end
            end else if (match[c]) begin
              wave_nxt[c] = 1'b0;
            end else if (at_bottom) begin
              wave_nxt[c] = 1'b1;
            end
          end else if (match[c]) begin
            case (compare_output_mode[c])
              COM_PAIR: wave_nxt[c] = ~r.wave[c];
              COM_CLEAR: wave_nxt[c] = 1'b0;
              COM_SET: wave_nxt[c] = 1'b1;
              default: wave_nxt[c] = r.wave[c];
            endcase
          end
        end
      end

      assign edge_seen = dt_on && (wave_nxt[c] != r.wave[c]);

      // A new edge during insertion restarts the count from the new value
      always_comb begin
        dtc_nxt[c] = r.dt_cnt[c];
        busy_nxt[c] = r.dt_busy[c];
        if (!dt_on) begin
          busy_nxt[c] = 1'b0;
        end else if (edge_seen) begin
          dtc_nxt[c] = wave_nxt[c] ? deadtime_high_value : deadtime_low_value;
          busy_nxt[c] = 1'b1;
        end else if (r.dt_busy[c] && dt_tick) begin
          if (r.dt_cnt[c] == '0) begin
            busy_nxt[c] = 1'b0;
          end else begin
            dtc_nxt[c] = r.dt_cnt[c] - 4'h1;
          end
        end
      end

      // Edge cycle always enters dead time, so the rising output lags at least one tick
      always_comb begin
        if (dt_on) begin
          true_nxt[c] = busy_nxt[c] ? 1'b0 : wave_nxt[c];
          comp_nxt[c] = busy_nxt[c] ? 1'b0 : ~wave_nxt[c];
          true_oe[c] = 1'b1;
          comp_oe[c] = 1'b1;
        end else begin
          true_nxt[c] = wave_nxt[c];
          comp_nxt[c] = 1'b0;
          true_oe[c] = (compare_output_mode[c] != COM_OFF);
          comp_oe[c] = 1'b0;
        end
      end

      // Pin 2c is the true output of the pair, pin 2c+1 its complement
      assign pin_nxt[2*c] = true_nxt[c];
      assign pin_nxt[2*c+1] = comp_nxt[c];
      assign oe_nxt[2*c] = true_oe[c];
      assign oe_nxt[2*c+1] = comp_oe[c];
    end
  endgenerate

  // APB decode
  // Two-cycle access phase: the answer is registered after the first access cycle
  logic acc;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [31:0] rd_val;
  logic [NCH-1:0] flag_clr;

  assign acc = psel && penable && !r.pready;
  assign wr_done = psel && penable && r.pready && pwrite;
  assign rd_done = psel && penable && r.pready && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    case (paddr)
      OFS_CTRL: rd_val = 32'(r.ctrl);
      OFS_COUNT: rd_val = 32'(r.cnt);
      OFS_CMP_A: rd_val = 32'(r.cmp_buf[0]);
      OFS_CMP_B: rd_val = 32'(r.cmp_buf[1]);
      OFS_CMP_C: rd_val = 32'(r.cmp_buf[2]);
      OFS_CMP_D: rd_val = 32'(r.cmp_buf[3]);
      OFS_DEADTIME: rd_val = 32'(r.dt_cfg);
      OFS_FLAGS: rd_val = 32'({pll_locked_flag, r.flag});
      OFS_MASK: rd_val = 32'(r.mask);
      default: mapped = 1'b0;
    endcase
  end

  // A status read clears only the bits it returned, so a flag set during the access survives
  always_comb begin
    flag_clr = '0;
    if (rd_done && (paddr == OFS_FLAGS)) begin
      flag_clr = r.prdata[NCH-1:0];
    end else if (wr_done && (paddr == OFS_FLAGS)) begin
      flag_clr = pwdata[NCH-1:0];
    end
  end

  always_comb begin
    n = r;
    n.tpre = r.tpre + 3'h1;
    n.pready = acc;
    n.pslverr = acc && !mapped;
    if (acc) begin
      n.prdata = pwrite ? 32'h00000000 : rd_val;
    end

    // Counter sequence and double-buffer transfer
    if (timer_clock_enable) begin
      n.dtpre = r.dtpre + 3'h1;
      if (phase_mode) begin
        if (r.dir == TCD_UP) begin
          if (at_top) begin
            n.dir = TCD_DOWN;
            n.cnt = r.cnt - 8'h01;
          end else begin
            n.cnt = r.cnt + 8'h01;
          end
        end else if (at_bottom) begin
          n.dir = TCD_UP;
          n.cnt = r.cnt + 8'h01;
          n.cmp_act = r.cmp_buf;
        end else begin
          n.cnt = r.cnt - 8'h01;
        end
      end else if (at_top) begin
        n.cnt = '0;
        n.dir = TCD_UP;
        if (pwm_any) begin
          n.cmp_act = r.cmp_buf;
        end
      end else begin
        n.cnt = r.cnt + 8'h01;
      end
    end
    if (!pwm_any) begin
      n.cmp_act = r.cmp_buf;
    end

    // Flags: read of the status register stands for servicing the interrupt
    // Pend holds this tick's match; it turns into a flag on the next tick
    if (timer_clock_enable) begin
      n.pend = match;
    end
    n.flag = r.flag & ~flag_clr;
    if (timer_clock_enable) begin
      n.flag = n.flag | r.pend;
    end

    // Register writes; a count write wins over the timer step
    if (wr_done) begin
      case (paddr)
        OFS_CTRL: n.ctrl = pwdata[CTRL_W-1:0];
        OFS_COUNT: n.cnt = pwdata[CNT_W-1:0];
        OFS_CMP_A: n.cmp_buf[0] = pwdata[CNT_W-1:0];
        OFS_CMP_B: n.cmp_buf[1] = pwdata[CNT_W-1:0];
        OFS_CMP_C: n.cmp_buf[2] = pwdata[CNT_W-1:0];
        OFS_CMP_D: n.cmp_buf[3] = pwdata[CNT_W-1:0];
        OFS_DEADTIME: n.dt_cfg = pwdata[DTCFG_W-1:0];
        OFS_MASK: n.mask = pwdata[NCH-1:0];
        default: n.mask = r.mask;
      endcase
    end

    n.wave = wave_nxt;
    n.dt_cnt = dtc_nxt;
    n.dt_busy = busy_nxt;
    n.pin = pin_nxt;
    n.pin_oe = oe_nxt;
    if (six_pwm) begin
      n.pin[4] = true_nxt[0] && pin4_output_gate;
      n.pin[5] = true_nxt[0] && pin5_output_gate;
      n.pin_oe[4] = (compare_output_mode[2] != COM_OFF);
      n.pin_oe[5] = (compare_output_mode[2] != COM_OFF);
      // Disconnected D pins carry no waveform either
      if (compare_output_mode[2] == COM_OFF) begin
        n.pin[5:4] = 2'b00;
      end
    end
    // Built from the next flags so the request rises with the flag itself
    n.irq = |(n.flag & n.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.ctrl <= CTRL_RST;
      r.cnt <= '0;
      r.dir <= TCD_UP;
      r.tpre <= '0;
      r.dtpre <= '0;
      r.cmp_buf <= {CMP_RST, TOP_RST, CMP_RST, CMP_RST};
      r.cmp_act <= {CMP_RST, TOP_RST, CMP_RST, CMP_RST};
      r.dt_cfg <= DTCFG_RST;
      r.pend <= '0;
      r.flag <= '0;
      r.mask <= '0;
      r.wave <= '0;
      r.dt_cnt <= '0;
      r.dt_busy <= '0;
      r.pin <= '0;
      r.pin_oe <= '0;
      r.irq <= 1'b0;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= '0;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign compare_pin = r.pin;
  assign compare_pin_oe = r.pin_oe;
  assign irq = r.irq;

endmodule

// file: common/tcd_pkg.sv
// Constants and state types for the compare and dead time timer block
package tcd_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 8;
  localparam int DT_W = 4;
  localparam int NCH = 3;
  localparam int NCMP = 4;
  localparam int NPIN = 6;
  localparam int CTRL_W = 18;
  localparam int DTCFG_W = 10;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMP_C = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP_D = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DEADTIME = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h20;

  // Control register fields
  localparam int CTRL_PWM_EN_LSB = 0;
  localparam int CTRL_WGM_LSB = 3;
  localparam int CTRL_COM_LSB = 5;
  localparam int CTRL_PWM6_BIT = 11;
  localparam int CTRL_GATE4_BIT = 12;
  localparam int CTRL_GATE5_BIT = 13;
  localparam int CTRL_CS_LSB = 14;
  localparam int CTRL_FAST_BIT = 17;

  // Dead time register fields
  localparam int DT_LOW_LSB = 0;
  localparam int DT_HIGH_LSB = 4;
  localparam int DT_PS_LSB = 8;

  localparam int FLAGS_LOCK_BIT = 3;
  localparam int CMP_IDX_TOP = 2;

  localparam logic [1:0] WGM_PHASE = 2'h1;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_PAIR = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [CTRL_W-1:0] CTRL_RST = 18'h00000;
  localparam logic [CNT_W-1:0] CMP_RST = 8'h00;
  localparam logic [CNT_W-1:0] TOP_RST = 8'hFF;
  localparam logic [DTCFG_W-1:0] DTCFG_RST = 10'h000;

  typedef enum logic {TCD_UP, TCD_DOWN} tcd_dir_e;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] cnt;
    tcd_dir_e dir;
    logic [2:0] tpre;
    logic [2:0] dtpre;
    logic [NCMP-1:0][CNT_W-1:0] cmp_buf;
    logic [NCMP-1:0][CNT_W-1:0] cmp_act;
    logic [DTCFG_W-1:0] dt_cfg;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] mask;
    logic [NCH-1:0] wave;
    logic [NCH-1:0][DT_W-1:0] dt_cnt;
    logic [NCH-1:0] dt_busy;
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] pin_oe;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tcd_state_s;
endpackage

// file: tb/tcd_timer_props.sv
// Port checker for the compare and dead time timer
`timescale 1ns/1ps
module tcd_timer_props
  import tcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt
  input wire logic pll_locked_flag,
  input wire logic [NPIN-1:0] compare_pin,
  input wire logic [NPIN-1:0] compare_pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_apb_answer: assert property (s_wait |=> pready) else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_map: assert property (s_done and paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_MASK))
    else $error("pslverr wrong");
  a_err_zero: assert property (s_done and pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
  a_upper_zero: assert property (s_done and !pwrite |-> prdata[31:CTRL_W] == '0) else $error("upper bits set");
  a_lock_seen: assert property (s_done and !pwrite && paddr == OFS_FLAGS |->
    prdata[FLAGS_LOCK_BIT] == $past(pll_locked_flag)) else $error("lock bit wrong");
  a_mask_quiet: assert property (s_done and pwrite && paddr == OFS_MASK && pwdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq while masked");
  a_pair_apart: assert property (!(compare_pin[0] && compare_pin[1]) && !(compare_pin[2] && compare_pin[3]))
    else $error("pair overlap");
  a_rise_gap: assert property ($rose(compare_pin[0]) && compare_pin_oe[1] |-> !$past(compare_pin[1]))
    else $error("no dead time");
endmodule

bind tcd_timer tcd_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pll_locked_flag(pll_locked_flag), .compare_pin(compare_pin), .compare_pin_oe(compare_pin_oe), .irq(irq));

// file: tb/tcd_sw_model.sv
// Power switch driver model that latches shoot-through on the A and B pairs (pins 0/1 and 2/3)
`timescale 1ns/1ps
module tcd_sw_model
  import tcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Gate inputs
  input wire logic [NPIN-1:0] gate,
  input wire logic [NPIN-1:0] gate_oe,
  // Status
  output logic shoot
);
  logic [NPIN-1:0] lvl;
  // Undriven gates read low through the driver pull-down
  assign lvl = gate & gate_oe;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shoot <= 1'b0;
    end else if ((lvl[0] && lvl[1]) || (lvl[2] && lvl[3])) begin
      shoot <= 1'b1;
    end
  end
endmodule

// file: tb/tcd_timer_tb_top.sv
// Self-checking bench for the compare and dead time timer
`timescale 1ns/1ps
module tcd_timer_tb_top;
  import tcd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pll_locked_flag, pready, pslverr, irq, shoot, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NPIN-1:0] compare_pin, compare_pin_oe;
  int miscompares, checked, cyc;
  tcd_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_locked_flag(pll_locked_flag), .compare_pin(compare_pin), .compare_pin_oe(compare_pin_oe), .irq(irq));
  tcd_sw_model u_sw (.pclk(pclk), .presetn(presetn), .gate(compare_pin), .gate_oe(compare_pin_oe), .shoot(shoot));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("Checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, well above the planned run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wirq();
    int k;
    for (k = 0; k < 100 && irq !== 1'b1; k++) @(posedge pclk);
    chk("irq_set", 1, irq);
  endtask
  // Counts the run of both-low cycles that ends when pin p rises
  task automatic gap(input int p, output int n);
    int k;
    n = 0;
    for (k = 0; k < 400 && !(compare_pin[p] && n > 0); k++) begin
      @(posedge pclk);
      n = (compare_pin[1:0] == 2'b00) ? n + 1 : (compare_pin[p] ? n : 0);
    end
  endtask
  task automatic t_regs();
    apb(0, OFS_CTRL, 0);
    chk("ctrl_rst", 0, rd);
    apb(0, OFS_CMP_C, 0);
    chk("top_rst", 32'hFF, rd);
    apb(0, OFS_DEADTIME, 0);
    chk("dt_rst", 0, rd);
    apb(0, 8'h24, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_rd", 0, rd);
  endtask
  task automatic t_flags();
    pll_locked_flag <= 1'b1;
    repeat (4000) @(posedge pclk);
    apb(0, OFS_FLAGS, 0);
    chk("lock", 1, rd[3]);
    apb(1, OFS_CMP_C, 32'h1F);
    apb(1, OFS_CMP_A, 32'h05);
    apb(1, OFS_CMP_D, 32'h15);
    apb(1, OFS_MASK, 32'h1);
    apb(1, OFS_CTRL, 32'h20000);
    wirq();
    apb(0, OFS_FLAGS, 0);
    chk("flags", 32'hB, rd);
    chk("irq_rdclr", 0, irq);
    wirq();
    apb(1, OFS_FLAGS, 32'h0);
    chk("irq_w0", 1, irq);
    apb(1, OFS_FLAGS, 32'h1);
    chk("irq_w1c", 0, irq);
    apb(1, OFS_MASK, 32'h0);
    repeat (40) @(posedge pclk);
    chk("irq_masked", 0, irq);
    apb(1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_dead(input logic [1:0] ps);
    int n, lo;
    apb(1, OFS_CMP_C, 32'h7F);
    apb(1, OFS_CMP_A, 32'h40);
    apb(1, OFS_DEADTIME, {22'h0, ps, 8'h32});
    apb(1, OFS_CTRL, 32'h4021);
    @(posedge pclk);
    chk("pair_oe", 2'b11, compare_pin_oe[1:0]);
    gap(0, n);
    gap(1, n);
    lo = (2 << ps) + 1;
    chk("dt_low", 1, n >= lo && n <= (3 << ps));
    gap(0, n);
    lo = (3 << ps) + 1;
    chk("dt_high", 1, n >= lo && n <= (4 << ps));
  endtask
  task automatic t_six();
    apb(1, OFS_CTRL, 32'h4061);
    @(posedge pclk);
    chk("no_pair_oe", 0, compare_pin_oe[1]);
    apb(1, OFS_CTRL, 32'h5A21);
    @(posedge pclk);
    chk("d_oe", 2'b11, compare_pin_oe[5:4]);
    repeat (130) begin
      @(posedge pclk);
      chk("pin4", compare_pin[0], compare_pin[4]);
      chk("pin5", 0, compare_pin[5]);
    end
    apb(1, OFS_CTRL, 32'h5821);
    @(posedge pclk);
    chk("d_off", 0, compare_pin_oe[5:4]);
  endtask
  // Length in cycles of the next complete run of level v on pin p
  task automatic run_len(input int p, input logic v, output int n);
    int k;
    n = 0;
    for (k = 0; k < 300 && compare_pin[p] === v; k++) @(posedge pclk);
    for (k = 0; k < 300 && compare_pin[p] !== v; k++) @(posedge pclk);
    for (k = 0; k < 300 && compare_pin[p] === v; k++) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Normal mode clear and set on match, then phase correct pulse lengths
  task automatic t_modes();
    int n;
    apb(1, OFS_CTRL, 32'h0);
    apb(1, OFS_COUNT, 32'h0);
    apb(1, OFS_CMP_C, 32'h10);
    apb(1, OFS_CMP_A, 32'h08);
    apb(1, OFS_CTRL, 32'h4040);
    repeat (40) @(posedge pclk);
    chk("clr_on_match", 0, compare_pin[0]);
    apb(1, OFS_CTRL, 32'h4060);
    repeat (40) @(posedge pclk);
    chk("set_on_match", 1, compare_pin[0]);
    apb(1, OFS_COUNT, 32'h0);
    apb(1, OFS_CTRL, 32'h4049);
    run_len(0, 1'b1, n);
    chk("phase_high", 16, n);
    run_len(0, 1'b0, n);
    chk("phase_low", 16, n);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pll_locked_flag = 1'b0;
    miscompares = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_flags();
    for (int p = 0; p < 4; p++) t_dead(p[1:0]);
    t_six();
    t_modes();
    chk("shoot", 0, shoot);
    end_of_test();
  end
endmodule
